// ### common/rsb_defs.svh
// constants for the serial burst port, both ends
`ifndef RSB_DEFS_SVH
`define RSB_DEFS_SVH
`define RSB_RTC_FIRST 7'h00
`define RSB_RTC_LAST 7'h1f
`define RSB_RAM_FIRST 7'h20
`define RSB_RAM_LAST 7'h7f
`define RSB_DIR_BIT 7
`define RSB_BIT_LAST 3'h7
`define RSB_SCLK_HALF 4'h3
`endif

// ### common/rsb_pkg.sv
// types shared by both ends of the serial burst port
package rsb_pkg;
	typedef enum logic [1:0] {RSB_S_IDLE, RSB_S_ADDR, RSB_S_DATA} rsb_phase_t;
	typedef enum logic [2:0] {RSB_M_IDLE, RSB_M_SETUP, RSB_M_LOW, RSB_M_HIGH, RSB_M_END} rsb_mstate_t;
endpackage

// ### common/rsb_if.sv
// link between master and device: ce, sclk, mode pin, shared or split data
`timescale 1ns/1ps
interface rsb_if;
	logic ce;
	logic sclk;
	logic interface_select_pin;
	logic serial_in_pin;
	logic serial_out_pin;
	logic serial_out_pin_oe_n;
	logic master_data;
	logic master_data_oe_n;
	modport device (
		input ce, sclk, interface_select_pin, serial_in_pin,
		output serial_out_pin, serial_out_pin_oe_n
	);
	modport master (
		output ce, sclk, interface_select_pin, master_data, master_data_oe_n,
		input serial_out_pin, serial_out_pin_oe_n
	);
endinterface

// ### hdl/rsb_device.sv
// device end of the serial burst port: shift engine, address pointer, byte port to storage
// Notes on behaviour
// - master holds ce and clocks through burst
// - bursts read and write both spaces
// - clock space pointer wraps 1fh to 00h
// - memory space pointer wraps 7fh to 20h
// - three-wire uses one shared data line
// - three-wire lsb first, spi msb first
// - master sends address byte then data
// - three-wire: sample rising, drive falling
// - mode pin low three-wire, high spi
// - address top bit: 0 read, 1 write
// - address increments after each data byte
// - spi idle polarity sampled at ce rise
`timescale 1ns/1ps
`include "rsb_defs.svh"
module rsb_device
	import rsb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	rsb_if.device bus,
	output logic [6:0] mem_addr_o,
	output logic mem_rd_o,
	input wire logic [7:0] mem_rdata_i,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o
);

////////////////////////////////////////////////////////////////
// pin synchronisers
logic [1:0] ce_s, sclk_s, mode_s, din_s;
logic ce_d, sclk_d;
always_ff @(posedge core_clk_i) begin
	if (rst_i) begin
		ce_s <= 2'h0;
		sclk_s <= 2'h0;
		mode_s <= 2'h0;
		din_s <= 2'h0;
		ce_d <= 1'b0;
		sclk_d <= 1'b0;
	end else begin
		ce_s <= {ce_s[0], bus.ce};
		sclk_s <= {sclk_s[0], bus.sclk};
		mode_s <= {mode_s[0], bus.interface_select_pin};
		din_s <= {din_s[0], bus.serial_in_pin};
		ce_d <= ce_s[1];
		sclk_d <= sclk_s[1];
	end
end
// ce and sclk pass equal depths, so the level seen at ce rise is the idle level
wire ce = ce_s[1];
wire ce_rise = ce & ~ce_d;
// edges count only inside a frame; sclk may move while ce is low
wire sclk_rise = ce & sclk_s[1] & ~sclk_d;
wire sclk_fall = ce & ~sclk_s[1] & sclk_d;

////////////////////////////////////////////////////////////////
// address stepping with space-local wrap
// one step of the pointer, kept inside its own space
function automatic logic [6:0] rsb_next_addr(input logic [6:0] a);
	if (a == `RSB_RTC_LAST)
		return `RSB_RTC_FIRST;
	else if (a == `RSB_RAM_LAST)
		return `RSB_RAM_FIRST;
	else
		return a + 7'h01;
endfunction

////////////////////////////////////////////////////////////////
// state
rsb_phase_t phase, next_phase;
logic spi, next_spi;
logic cpol, next_cpol;
logic wr, next_wr;
logic [2:0] cnt, next_cnt;
logic [7:0] sh, next_sh;
logic [7:0] tx, next_tx;
logic [6:0] addr, next_addr;
logic [6:0] addr_prev, next_addr_prev;
logic dout, next_dout;
logic oe_n, next_oe_n;
logic rd, next_rd;
logic wrp, next_wrp;
logic [7:0] wdata, next_wdata;

// in spi the sample edge is the leading edge for the captured polarity
wire samp = spi ? (cpol ? sclk_fall : sclk_rise) : sclk_rise;
wire shft = spi ? (cpol ? sclk_rise : sclk_fall) : sclk_fall;
wire [7:0] in_byte = spi ? {sh[6:0], din_s[1]} : {din_s[1], sh[7:1]};

always_comb begin
	next_phase = phase;
	next_spi = spi;
	next_cpol = cpol;
	next_wr = wr;
	next_cnt = cnt;
	next_sh = sh;
	next_tx = tx;
	next_addr = addr;
	next_dout = dout;
	next_oe_n = oe_n;
	next_rd = 1'b0;
	next_wrp = 1'b0;
	next_wdata = wdata;
	// a dropped ce ends the frame at once and frees the line for the master
	if (!ce) begin
		next_phase = RSB_S_IDLE;
		next_oe_n = 1'b1;
	end else if (ce_rise) begin
		next_phase = RSB_S_ADDR;
		next_spi = mode_s[1];
		next_cpol = sclk_s[1];
		next_cnt = 3'h0;
		next_oe_n = 1'b1;
	end else begin
		if (samp) begin
			next_sh = in_byte;
			next_cnt = cnt + 3'h1;
			if (cnt == `RSB_BIT_LAST) begin
				next_cnt = 3'h0;
				if (phase == RSB_S_ADDR) begin
					next_phase = RSB_S_DATA;
					next_wr = in_byte[`RSB_DIR_BIT];
					next_addr = in_byte[6:0];
					next_rd = ~in_byte[`RSB_DIR_BIT];
				end else if (phase == RSB_S_DATA) begin
					if (wr) begin
						next_wrp = 1'b1;
						next_wdata = in_byte;
					end else begin
						next_rd = 1'b1;
					end
					// reads fetch ahead: the byte after the last one sent is fetched and dropped
					next_addr = rsb_next_addr(addr);
				end
			end
		end
		// storage answers in the same cycle, so the byte is caught right after the strobe
		if (rd)
			next_tx = mem_rdata_i;
		// data bytes of a read go out on the shift edge
		if (shft && phase == RSB_S_DATA && !wr) begin
			next_dout = spi ? tx[`RSB_BIT_LAST - cnt] : tx[cnt];
			next_oe_n = 1'b0;
		end
		// a write frame never drives, whatever the shift edges say
		if (phase == RSB_S_DATA && wr)
			next_oe_n = 1'b1;
	end
end

always_ff @(posedge core_clk_i) begin
	if (rst_i) begin
		phase <= RSB_S_IDLE;
		spi <= 1'b0;
		cpol <= 1'b0;
		wr <= 1'b0;
		cnt <= 3'h0;
		sh <= 8'h00;
		tx <= 8'h00;
		addr <= 7'h00;
		dout <= 1'b0;
		oe_n <= 1'b1;
		rd <= 1'b0;
		wrp <= 1'b0;
		wdata <= 8'h00;
	end else begin
		phase <= next_phase;
		spi <= next_spi;
		cpol <= next_cpol;
		wr <= next_wr;
		cnt <= next_cnt;
		sh <= next_sh;
		tx <= next_tx;
		addr <= next_addr;
		dout <= next_dout;
		oe_n <= next_oe_n;
		rd <= next_rd;
		wrp <= next_wrp;
		wdata <= next_wdata;
	end
end

////////////////////////////////////////////////////////////////
// pin drive and byte port to storage
assign bus.serial_out_pin = dout;
assign bus.serial_out_pin_oe_n = oe_n;
assign mem_addr_o = wrp ? addr_prev : addr;
assign mem_rd_o = rd;
assign mem_wr_o = wrp;
assign mem_wdata_o = wdata;

// write strobe names the address before the step
always_comb begin
	next_addr_prev = addr_prev;
	if (samp && cnt == `RSB_BIT_LAST && phase == RSB_S_DATA)
		next_addr_prev = addr;
end
always_ff @(posedge core_clk_i) begin
	if (rst_i)
		addr_prev <= 7'h00;
	else
		addr_prev <= next_addr_prev;
end

endmodule

// ### hdl/rsb_master.sv
// master end: frames ce, divides sclk, sends address and data, collects read bytes
`timescale 1ns/1ps
`include "rsb_defs.svh"
module rsb_master
	import rsb_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	rsb_if.master bus,
	input wire logic spi_mode_i,
	input wire logic cpol_i,
	input wire logic start_i,
	input wire logic [7:0] addr_byte_i,
	input wire logic [7:0] wdata_i,
	input wire logic last_i,
	output logic busy_o,
	output logic byte_next_o,
	output logic rvalid_o,
	output logic [7:0] rdata_o
);

////////////////////////////////////////////////////////////////
logic [1:0] din_s;
always_ff @(posedge core_clk_i) begin
	if (rst_i)
		din_s <= 2'h0;
	else
		din_s <= {din_s[0], spi_mode_i ? bus.serial_out_pin : (bus.serial_out_pin_oe_n ? 1'b1 : bus.serial_out_pin)};
end

rsb_mstate_t st, next_st;
logic ce, next_ce, sclk, next_sclk, mode, next_mode, pol, next_pol;
logic [3:0] div, next_div;
logic [2:0] cnt, next_cnt;
logic [7:0] sh, next_sh, rsh, next_rsh, rdata, next_rdata;
logic addr_ph, next_addr_ph, rdir, next_rdir, fin, next_fin;
logic dat, next_dat, oe_n, next_oe_n, bn, next_bn, rv, next_rv;
// the line is taken at the end of the sample phase: the device's edge detect plus two sync
// stages put its bit on din_s[1] one cycle after the sample edge itself
wire [7:0] rsh_in = mode ? {rsh[6:0], din_s[1]} : {din_s[1], rsh[7:1]};

function automatic logic pick(input logic [7:0] b, input logic [2:0] i, input logic msb);
	return msb ? b[`RSB_BIT_LAST - i] : b[i];
endfunction

always_comb begin
	next_st = st;
	next_ce = ce;
	next_sclk = sclk;
	next_mode = mode;
	next_pol = pol;
	next_div = div;
	next_cnt = cnt;
	next_sh = sh;
	next_rsh = rsh;
	next_rdata = rdata;
	next_addr_ph = addr_ph;
	next_rdir = rdir;
	next_fin = fin;
	next_dat = dat;
	next_oe_n = oe_n;
	next_bn = 1'b0;
	next_rv = 1'b0;
	unique case (st)
		RSB_M_IDLE: begin
			next_oe_n = 1'b1;
			if (start_i) begin
				next_mode = spi_mode_i;
				next_pol = spi_mode_i & cpol_i;
				next_sclk = spi_mode_i & cpol_i;
				next_sh = addr_byte_i;
				next_rdir = ~addr_byte_i[`RSB_DIR_BIT];
				next_addr_ph = 1'b1;
				next_fin = last_i;
				next_cnt = 3'h0;
				next_div = 4'h0;
				next_st = RSB_M_SETUP;
			end
		end
		RSB_M_SETUP: begin
			next_ce = 1'b1;
			next_dat = pick(sh, 3'h0, mode);
			next_oe_n = 1'b0;
			next_div = div + 4'h1;
			if (div == `RSB_SCLK_HALF) begin
				next_div = 4'h0;
				next_st = RSB_M_LOW;
			end
		end
		RSB_M_LOW: begin
			next_div = div + 4'h1;
			if (div == `RSB_SCLK_HALF) begin
				next_div = 4'h0;
				next_sclk = ~pol; // sample edge
				next_st = RSB_M_HIGH;
			end
		end
		RSB_M_HIGH: begin
			next_div = div + 4'h1;
			if (div == `RSB_SCLK_HALF) begin
				next_div = 4'h0;
				next_sclk = pol;
				next_rsh = rsh_in;
				next_cnt = cnt + 3'h1;
				next_st = RSB_M_LOW;
				if (cnt == `RSB_BIT_LAST) begin
					if (!addr_ph && rdir) begin
						next_rdata = rsh_in;
						next_rv = 1'b1;
					end
					if (!addr_ph && fin) begin
						next_st = RSB_M_END;
					end else begin
						next_addr_ph = 1'b0;
						next_sh = wdata_i;
						next_fin = addr_ph ? fin : last_i;
						next_bn = 1'b1;
						next_oe_n = ~(mode | ~rdir);
						next_dat = pick(wdata_i, 3'h0, mode);
					end
				end else begin
					next_dat = pick(sh, cnt + 3'h1, mode);
				end
			end
		end
		RSB_M_END: begin
			next_div = div + 4'h1;
			if (div == `RSB_SCLK_HALF) begin
				next_ce = 1'b0;
				next_oe_n = 1'b1;
				next_st = RSB_M_IDLE;
			end
		end
		default: next_st = RSB_M_IDLE;
	endcase
end

always_ff @(posedge core_clk_i) begin
	if (rst_i) begin
		st <= RSB_M_IDLE;
		ce <= 1'b0;
		sclk <= 1'b0;
		mode <= 1'b0;
		pol <= 1'b0;
		div <= 4'h0;
		cnt <= 3'h0;
		sh <= 8'h00;
		rsh <= 8'h00;
		rdata <= 8'h00;
		addr_ph <= 1'b0;
		rdir <= 1'b0;
		fin <= 1'b0;
		dat <= 1'b0;
		oe_n <= 1'b1;
		bn <= 1'b0;
		rv <= 1'b0;
	end else begin
		st <= next_st;
		ce <= next_ce;
		sclk <= next_sclk;
		mode <= next_mode;
		pol <= next_pol;
		div <= next_div;
		cnt <= next_cnt;
		sh <= next_sh;
		rsh <= next_rsh;
		rdata <= next_rdata;
		addr_ph <= next_addr_ph;
		rdir <= next_rdir;
		fin <= next_fin;
		dat <= next_dat;
		oe_n <= next_oe_n;
		bn <= next_bn;
		rv <= next_rv;
	end
end

assign bus.ce = ce;
assign bus.sclk = sclk;
assign bus.interface_select_pin = spi_mode_i;
assign bus.master_data = dat;
assign bus.master_data_oe_n = oe_n;
assign busy_o = (st != RSB_M_IDLE);
assign byte_next_o = bn;
assign rvalid_o = rv;
assign rdata_o = rdata;

endmodule

// ### sim/rsb_properties.sv
// link assertions between the master and device ends
`timescale 1ns/1ps
module rsb_properties (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce,
	input wire logic sclk,
	input wire logic interface_select_pin,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic serial_out_pin_oe_n,
	input wire logic master_data,
	input wire logic master_data_oe_n
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// rising sclk edges counted inside each frame
	logic sclk_q;
	logic [7:0] rises;
	logic [7:0] next_rises;
	always_comb begin
		next_rises = (rst_i || !ce) ? 8'h00 : rises + {7'h00, sclk & ~sclk_q};
	end
	always_ff @(posedge core_clk_i) begin
		sclk_q <= sclk;
		rises <= next_rises;
	end
	////////////////////////////////////////////////////////////////
	sequence s_open;
		$rose(ce);
	endsequence
	sequence s_hold;
		$stable(sclk)[*3];
	endsequence
	a_polarity_setup: assert property (s_open |-> s_hold)
		else $error("sclk moved during frame setup");
	a_half_period: assert property (ce && $changed(sclk) |=> s_hold)
		else $error("sclk half period too short");
	a_frame_bytes: assert property ($fell(ce) |-> rises[2:0] == 3'h0 && rises >= 8'h10)
		else $error("frame not address plus whole data bytes");
	a_mode_steady: assert property (ce && $past(ce) |-> $stable(interface_select_pin))
		else $error("mode pin changed in frame");
	a_one_driver: assert property (!interface_select_pin |-> serial_out_pin_oe_n || master_data_oe_n)
		else $error("both ends drive the shared line");
	a_no_addr_drive: assert property (ce && !interface_select_pin && !serial_out_pin_oe_n |-> rises >= 8'h08)
		else $error("device drove during address byte");
	a_release_end: assert property ($fell(ce) |-> ##[0:4] serial_out_pin_oe_n)
		else $error("device kept line after frame");
	a_drive_falling: assert property (!interface_select_pin && !serial_out_pin_oe_n
		&& $changed(serial_out_pin) |-> !sclk)
		else $error("device output changed outside low phase");
	a_data_held: assert property (!interface_select_pin && ce && !master_data_oe_n && $rose(sclk)
		|-> $stable(master_data))
		else $error("master data moved at sample edge");
endmodule

// ### sim/rtc_serial_burst_three_wire_tb.sv
// self-checking bench: master and device ends joined on one link
`timescale 1ns/1ps
module rtc_serial_burst_three_wire_tb;
	logic core_clk_i = 0;
	logic rst_i = 1;
	logic spi_mode = 0, cpol = 0, start = 0, last = 0;
	logic [7:0] addr_byte = 0, wdata = 0, exp_ab = 0, ab, rdata, mem_wdata;
	logic busy, byte_next, rvalid, mem_rd, mem_wr;
	logic [6:0] mem_addr;
	logic [7:0] mem[128], shadow[128];
	logic [15:0] wq[$], rq[$];
	int n_fail = 0, tests_run = 0, nb = 0;
	integer seed = 32'h06a0;
	always #50 core_clk_i = ~core_clk_i;
	rsb_if bus();
	// spi: master always drives; three-wire shared line: whoever enables drives, master first, else pull-up
	assign bus.serial_in_pin = bus.interface_select_pin ? bus.master_data : !bus.master_data_oe_n ?
		bus.master_data : !bus.serial_out_pin_oe_n ? bus.serial_out_pin : 1'b1;
	rsb_master rsb_master_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bus), .spi_mode_i(spi_mode),
		.cpol_i(cpol), .start_i(start), .addr_byte_i(addr_byte), .wdata_i(wdata), .last_i(last),
		.busy_o(busy), .byte_next_o(byte_next), .rvalid_o(rvalid), .rdata_o(rdata));
	rsb_device rsb_device_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus(bus), .mem_addr_o(mem_addr),
		.mem_rd_o(mem_rd), .mem_rdata_i(mem[mem_addr]), .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata));
	rsb_properties rsb_properties_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce(bus.ce), .sclk(bus.sclk),
		.interface_select_pin(bus.interface_select_pin), .serial_in_pin(bus.serial_in_pin),
		.serial_out_pin(bus.serial_out_pin), .serial_out_pin_oe_n(bus.serial_out_pin_oe_n),
		.master_data(bus.master_data), .master_data_oe_n(bus.master_data_oe_n));
	////////////////////////////////////////////////////////////////
	function automatic logic [6:0] nxt(input logic [6:0] a);
		return a == 7'h1f ? 7'h00 : a == 7'h7f ? 7'h20 : a + 7'h01;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watcher: storage writes and read bytes against the oldest note
	always @(posedge core_clk_i) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
			chk("wr", wq.size() ? wq.pop_front() : 16'h8000, {1'b0, mem_addr, mem_wdata});
		end
		if (rvalid) chk("rd", rq.size() ? rq.pop_front() : 16'h8000, {8'h00, rdata});
		if (mem_rd) chk("rdir", 16'h0, {15'h0, exp_ab[7]});
	end
	// the address byte as seen on the wire, rebuilt by bit order
	always @(posedge bus.ce) begin
		nb = 0;
		chk("idle", {15'h0, cpol}, {15'h0, bus.sclk});
	end
	always @(bus.sclk) if (bus.ce && bus.sclk !== cpol && nb < 8) begin
		ab[bus.interface_select_pin ? 7 - nb : nb] = bus.serial_in_pin;
		nb++;
		if (nb == 8) chk("addr", {8'h0, exp_ab}, {8'h0, ab});
	end
	////////////////////////////////////////////////////////////////
	task automatic xfer(input logic sp, cp, wr, input logic [6:0] a, input int n);
		logic [7:0] d[8];
		int k, t;
		logic pend;
		spi_mode = sp;
		cpol = cp;
		addr_byte = {wr, a};
		exp_ab = {wr, a};
		for (k = 0; k < n; k++) begin
			d[k] = 8'($random(seed));
			if (wr) begin
				shadow[a] = d[k];
				wq.push_back({1'b0, a, d[k]});
			end else rq.push_back({8'h00, shadow[a]});
			a = nxt(a);
		end
		wdata = d[0];
		last = n == 1;
		start = 1;
		k = 0;
		pend = 0;
		for (t = 0; t < 4000 && (t < 3 || busy); t++) begin
			@(posedge core_clk_i);
			#1;
			start = 0;
			if (pend) begin
				k++;
				wdata = d[k];
				last = k == n - 1;
			end
			pend = byte_next;
		end
		if (t == 4000) begin
			n_fail++;
			$display("[ERR] busy exp 0 got 1");
			end_sim();
		end
		// let the device see ce low and free the line before the next frame
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	initial begin
		for (int i = 0; i < 128; i++) begin
			shadow[i] = 8'($random(seed));
			mem[i] = shadow[i];
		end
		repeat (2) @(posedge core_clk_i);
		#1 rst_i = 0;
		for (int m = 0; m < 4; m++) begin
			xfer(m[1], m[1] & m[0], 1, m[0] ? 7'h7e : 7'h1e, 3);
			xfer(m[1], m[1] & m[0], 0, m[0] ? 7'h7e : 7'h1e, 4);
		end
		xfer(0, 0, 1, 7'h05, 1);
		xfer(0, 0, 0, 7'h05, 1);
		repeat (4) @(posedge core_clk_i);
		chk("left", 16'h0, 16'(wq.size() + rq.size()));
		end_sim();
	end
endmodule
